// ===== design/acr_pkg.sv
package acr_pkg;

    // ****************************************
    // Register map (byte addresses, 32-bit words)
    // ****************************************
    localparam logic [7:0] ACR_CONFIG_IDX     = 8'h9F;
    localparam logic [9:0] ACR_CONFIG_ADDR    = 10'h27C;
    localparam logic [9:0] ACR_CONTROL_ADDR   = 10'h000;
    localparam logic [9:0] ACR_RESULT_ADDR    = 10'h004;
    localparam logic [9:0] ACR_STATUS_ADDR    = 10'h008;
    localparam int         ACR_ADDR_W         = 10;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int ACR_JUSTIFY_BIT   = 7;
    localparam int ACR_DIV_HIGH_BIT  = 6;
    localparam int ACR_MAP_LSB       = 0;
    localparam int ACR_MAP_W         = 4;
    localparam int ACR_SEL_LSB       = 6;
    localparam int ACR_SEL_W         = 2;

    // ****************************************
    // Reset values and config write mask
    // ****************************************
    localparam logic [7:0] ACR_CONFIG_RESET  = 8'h00;
    localparam logic [7:0] ACR_CONFIG_WMASK  = 8'hCF;
    localparam logic [7:0] ACR_CONTROL_RESET = 8'h00;

    // ****************************************
    // Clock source codes and divide ratios
    // ****************************************
    localparam logic [1:0] ACR_SEL_RC        = 2'h3;
    localparam logic [6:0] ACR_DIV_2         = 7'h02;
    localparam logic [6:0] ACR_DIV_4         = 7'h04;
    localparam logic [6:0] ACR_DIV_8         = 7'h08;
    localparam logic [6:0] ACR_DIV_16        = 7'h10;
    localparam logic [6:0] ACR_DIV_32        = 7'h20;
    localparam logic [6:0] ACR_DIV_64        = 7'h40;

    // ****************************************
    // Port map codes
    // ****************************************
    localparam logic [3:0] ACR_MAP_ALL_ANALOG = 4'h0;
    localparam logic [3:0] ACR_MAP_TWO_REFS   = 4'h8;
    localparam logic [3:0] ACR_MAP_ONE_CHAN   = 4'hE;

    // Reference source codes
    typedef enum logic [1:0] {
        ACR_REF_RAILS = 2'b00,
        ACR_REF_CH3   = 2'b01,
        ACR_REF_CH32  = 2'b10,
        ACR_REF_NONE  = 2'b11
    } acr_ref_type;

    typedef enum logic [0:0] {
        ACR_BUS_IDLE = 1'b0,
        ACR_BUS_ACK  = 1'b1
    } acr_bus_type;

endpackage

// ===== design/acr_port_decode.sv
`timescale 1ns/10ps
`default_nettype none
module acr_port_decode
    import acr_pkg::*;
(
    input  wire logic [3:0] map_in,
    output logic      [7:0] analog_out,
    output acr_ref_type     ref_out
);

    // ****************************************
    // Pin map and reference decode
    // ****************************************
    always_comb
    begin
        analog_out = 8'h00;
        ref_out    = ACR_REF_RAILS;
        case (map_in)
            4'h0:
            begin
                analog_out = 8'hFF;
                ref_out = ACR_REF_RAILS;
            end
            4'h1:
            begin
                analog_out = 8'hF7;
                ref_out = ACR_REF_CH3;
            end
            4'h2:
            begin
                analog_out = 8'h1F;
                ref_out = ACR_REF_RAILS;
            end
            4'h3:
            begin
                analog_out = 8'h17;
                ref_out = ACR_REF_CH3;
            end
            4'h4:
            begin
                analog_out = 8'h0B;
                ref_out = ACR_REF_RAILS;
            end
            4'h5:
            begin
                analog_out = 8'h03;
                ref_out = ACR_REF_CH3;
            end
            4'h6, 4'h7:
            begin
                analog_out = 8'h00;
                ref_out = ACR_REF_NONE;
            end
            4'h8:
            begin
                analog_out = 8'hF3;
                ref_out = ACR_REF_CH32;
            end
            4'h9:
            begin
                analog_out = 8'h3F;
                ref_out = ACR_REF_RAILS;
            end
            4'hA:
            begin
                analog_out = 8'h37;
                ref_out = ACR_REF_CH3;
            end
            4'hB:
            begin
                analog_out = 8'h33;
                ref_out = ACR_REF_CH32;
            end
            4'hC:
            begin
                analog_out = 8'h13;
                ref_out = ACR_REF_CH32;
            end
            4'hD:
            begin
                analog_out = 8'h03;
                ref_out = ACR_REF_CH32;
            end
            4'hE:
            begin
                analog_out = 8'h01;
                ref_out = ACR_REF_RAILS;
            end
            4'hF:
            begin
                analog_out = 8'h01;
                ref_out = ACR_REF_CH32;
            end
            default:
            begin
                analog_out = 8'hFF;
                ref_out = ACR_REF_RAILS;
            end
        endcase
    end

endmodule
`default_nettype wire

// ===== design/acr_config.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module acr_config
    import acr_pkg::*;
(
    input  wire logic                  clock_in,
    input  wire logic                  rst_in,
    input  wire logic [ACR_ADDR_W-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    input  wire logic [9:0]            conv_result_in,
    output logic      [7:0]            result_high_byte_out,
    output logic      [7:0]            result_low_byte_out,
    output logic      [7:0]            analog_pin_out,
    output acr_ref_type                ref_sel_out,
    output logic                       use_rc_clock_out,
    output logic      [6:0]            clock_div_out,
    output logic                       conv_clock_tick_out
);

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0]  converter_config_reg;
    logic [7:0]  next_converter_config_reg;
    logic [7:0]  converter_control_reg;
    logic [7:0]  next_converter_control_reg;
    acr_bus_type bus_state;
    acr_bus_type next_bus_state;
    logic [31:0] next_readdata;
    logic [31:0] readdata;
    logic        result_justify_sel;
    logic        clock_div_high_sel;
    logic [1:0]  clock_div_sel;
    logic [3:0]  port_analog_map;
    logic        wr_hit;

    assign result_justify_sel = converter_config_reg[ACR_JUSTIFY_BIT];
    assign clock_div_high_sel = converter_config_reg[ACR_DIV_HIGH_BIT];
    assign port_analog_map    = converter_config_reg[ACR_MAP_LSB +: ACR_MAP_W];
    assign clock_div_sel      = converter_control_reg[ACR_SEL_LSB +: ACR_SEL_W];

    // ****************************************
    // Avalon slave: one wait state per access
    // ****************************************
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && (bus_state == ACR_BUS_IDLE);
    assign wr_hit = avs_write_in && (bus_state == ACR_BUS_ACK) && avs_byteenable_in[0];
    assign avs_readdata_out = readdata;

    always_comb
    begin
        next_bus_state             = ACR_BUS_IDLE;
        next_converter_config_reg  = converter_config_reg;
        next_converter_control_reg = converter_control_reg;
        next_readdata              = readdata;
        if ((avs_read_in || avs_write_in) && bus_state == ACR_BUS_IDLE)
        begin
            next_bus_state = ACR_BUS_ACK;
            next_readdata  = 32'h0000_0000;
            case (avs_address_in)
                ACR_CONFIG_ADDR:
                    next_readdata[7:0] = converter_config_reg & ACR_CONFIG_WMASK;
                ACR_CONTROL_ADDR:
                    next_readdata[7:0] = converter_control_reg;
                ACR_RESULT_ADDR:
                    next_readdata[15:0] = {result_high_byte_out, result_low_byte_out};
                ACR_STATUS_ADDR:
                    next_readdata[9:0] = {ref_sel_out, analog_pin_out};
                default:
                    next_readdata = 32'h0000_0000;
            endcase
        end
        if (wr_hit)
        begin
            case (avs_address_in)
                ACR_CONFIG_ADDR:
                    next_converter_config_reg = avs_writedata_in[7:0] & ACR_CONFIG_WMASK;
                ACR_CONTROL_ADDR:
                    next_converter_control_reg = avs_writedata_in[7:0];
                default:
                    next_converter_config_reg = converter_config_reg;
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            converter_config_reg  <= ACR_CONFIG_RESET;
            converter_control_reg <= ACR_CONTROL_RESET;
            bus_state             <= ACR_BUS_IDLE;
            readdata              <= 32'h0000_0000;
        end
        else
        begin
            converter_config_reg  <= next_converter_config_reg;
            converter_control_reg <= next_converter_control_reg;
            bus_state             <= next_bus_state;
            readdata              <= next_readdata;
        end
    end

    // ****************************************
    // Pin map decode
    // ****************************************
    acr_port_decode u_decode
    (
        .map_in     (port_analog_map),
        .analog_out (analog_pin_out),
        .ref_out    (ref_sel_out)
    );

    // ****************************************
    // Result justification
    // ****************************************
    logic [7:0] next_high;
    logic [7:0] next_low;
    logic [7:0] res_high;
    logic [7:0] res_low;

    always_comb
    begin
        if (result_justify_sel)
        begin
            next_high = {6'h00, conv_result_in[9:8]};
            next_low  = conv_result_in[7:0];
        end
        else
        begin
            next_high = conv_result_in[9:2];
            next_low  = {conv_result_in[1:0], 6'h00};
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            res_high <= 8'h00;
            res_low  <= 8'h00;
        end
        else
        begin
            res_high <= next_high;
            res_low  <= next_low;
        end
    end

    assign result_high_byte_out = res_high;
    assign result_low_byte_out  = res_low;

    // ****************************************
    // Conversion clock select and divider
    // ****************************************
    logic [6:0] next_div;
    logic       next_rc;
    logic [6:0] div_reg;
    logic       rc_reg;
    logic [5:0] div_cnt;
    logic [5:0] next_div_cnt;
    logic       next_tick;
    logic       tick;

    always_comb
    begin
        next_rc  = 1'b0;
        next_div = ACR_DIV_2;
        case (clock_div_sel)
            2'h0:    next_div = clock_div_high_sel ? ACR_DIV_4  : ACR_DIV_2;
            2'h1:    next_div = clock_div_high_sel ? ACR_DIV_16 : ACR_DIV_8;
            2'h2:    next_div = clock_div_high_sel ? ACR_DIV_64 : ACR_DIV_32;
            default: next_rc  = 1'b1;
        endcase
        next_tick    = 1'b0;
        next_div_cnt = div_cnt + 6'h01;
        if (next_rc || rc_reg || div_cnt >= 6'(div_reg - 7'h01) || div_reg != next_div)
        begin
            next_div_cnt = 6'h00;
            next_tick    = !next_rc && !rc_reg && (div_reg == next_div);
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            div_reg <= ACR_DIV_2;
            rc_reg  <= 1'b0;
            div_cnt <= 6'h00;
            tick    <= 1'b0;
        end
        else
        begin
            div_reg <= next_div;
            rc_reg  <= next_rc;
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
        end
    end

    assign use_rc_clock_out    = rc_reg;
    assign clock_div_out       = rc_reg ? 7'h00 : div_reg;
    assign conv_clock_tick_out = tick;

    // ****************************************
    // Checks
    // ****************************************
    right_just_a: assert property (@(posedge clock_in) disable iff (rst_in)
        $past(result_justify_sel) |-> result_high_byte_out[7:2] == 6'h00)
        else $error("right justified high byte not zero");
    left_just_a: assert property (@(posedge clock_in) disable iff (rst_in)
        !$past(result_justify_sel) |-> result_low_byte_out[5:0] == 6'h00)
        else $error("left justified low byte not zero");
    div_sel_a: assert property (@(posedge clock_in) disable iff (rst_in)
        (clock_div_sel == 2'h2 && clock_div_high_sel) ##1 $stable(converter_control_reg)
        |-> clock_div_out == ACR_DIV_64)
        else $error("divider select wrong");
    rc_sel_a: assert property (@(posedge clock_in) disable iff (rst_in)
        clock_div_sel == ACR_SEL_RC |=> use_rc_clock_out && !conv_clock_tick_out)
        else $error("rc clock not selected");
    unimpl_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
        converter_config_reg[5:4] == 2'h0)
        else $error("unimplemented bits set");
    map_one_a: assert property (@(posedge clock_in) disable iff (rst_in)
        port_analog_map == ACR_MAP_ONE_CHAN |-> analog_pin_out == 8'h01)
        else $error("one channel map wrong");
    map_refs_a: assert property (@(posedge clock_in) disable iff (rst_in)
        port_analog_map == ACR_MAP_TWO_REFS |-> ref_sel_out == ACR_REF_CH32
        && analog_pin_out == 8'hF3)
        else $error("two reference map wrong");
    reset_analog_a: assert property (@(posedge clock_in)
        $past(rst_in) |-> analog_pin_out == 8'hFF)
        else $error("pins not analog after reset");
    write_take_a: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_hit && avs_address_in == ACR_CONFIG_ADDR
        |=> converter_config_reg == ($past(avs_writedata_in[7:0]) & ACR_CONFIG_WMASK))
        else $error("config write not taken");

endmodule
`default_nettype wire

// ===== verif/acr_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module acr_config_tb
    import acr_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  ctl;
        logic [7:0]  pins;
        acr_ref_type rf;
    } acr_row_type;

    logic        clock_in;
    logic        rst_in;
    logic [9:0]  avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic [9:0]  conv_result_in;
    logic [7:0]  result_high_byte_out;
    logic [7:0]  result_low_byte_out;
    logic [7:0]  analog_pin_out;
    acr_ref_type ref_sel_out;
    logic        use_rc_clock_out;
    logic [6:0]  clock_div_out;
    logic        conv_clock_tick_out;
    int          n_mismatch;
    int          comparisons;
    int          cycles;
    int          n;
    logic [31:0] rd;
    acr_row_type rows [16] = '{
        '{8'h30, 8'h00, 8'hFF, ACR_REF_RAILS}, '{8'h71, 8'h40, 8'hF7, ACR_REF_CH3},
        '{8'hB2, 8'h80, 8'h1F, ACR_REF_RAILS}, '{8'hF3, 8'hC0, 8'h17, ACR_REF_CH3},
        '{8'h44, 8'h00, 8'h0B, ACR_REF_RAILS}, '{8'h05, 8'h40, 8'h03, ACR_REF_CH3},
        '{8'h46, 8'h80, 8'h00, ACR_REF_NONE},  '{8'h07, 8'hC0, 8'h00, ACR_REF_NONE},
        '{8'h38, 8'h00, 8'hF3, ACR_REF_CH32},  '{8'h79, 8'h40, 8'h3F, ACR_REF_RAILS},
        '{8'h3A, 8'h80, 8'h37, ACR_REF_CH3},   '{8'hFB, 8'hC0, 8'h33, ACR_REF_CH32},
        '{8'h8C, 8'h00, 8'h13, ACR_REF_CH32},  '{8'hCD, 8'h40, 8'h03, ACR_REF_CH32},
        '{8'h8E, 8'h80, 8'h01, ACR_REF_RAILS}, '{8'h4F, 8'hC0, 8'h01, ACR_REF_CH32}
    };

    acr_config u_dut (
        .clock_in             (clock_in),
        .rst_in               (rst_in),
        .avs_address_in       (avs_address_in),
        .avs_read_in          (avs_read_in),
        .avs_write_in         (avs_write_in),
        .avs_writedata_in     (avs_writedata_in),
        .avs_byteenable_in    (avs_byteenable_in),
        .avs_readdata_out     (avs_readdata_out),
        .avs_waitrequest_out  (avs_waitrequest_out),
        .conv_result_in       (conv_result_in),
        .result_high_byte_out (result_high_byte_out),
        .result_low_byte_out  (result_low_byte_out),
        .analog_pin_out       (analog_pin_out),
        .ref_sel_out          (ref_sel_out),
        .use_rc_clock_out     (use_rc_clock_out),
        .clock_div_out        (clock_div_out),
        .conv_clock_tick_out  (conv_clock_tick_out)
    );

    // ****************************************
    // Clock and timeout
    // ****************************************
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [6:0] div_of(input logic h, input logic [1:0] s);
        case (s)
            2'h0:    return h ? ACR_DIV_4 : ACR_DIV_2;
            2'h1:    return h ? ACR_DIV_16 : ACR_DIV_8;
            2'h2:    return h ? ACR_DIV_64 : ACR_DIV_32;
            default: return 7'h00;
        endcase
    endfunction

    function automatic logic [15:0] just_of(input logic j, input logic [9:0] r);
        return j ? {6'h00, r} : {r, 6'h00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus_cycle(input logic wr, input logic [9:0] a, input logic [31:0] d,
                             input logic [3:0] be, output logic [31:0] q);
        @(posedge clock_in);
        avs_address_in    <= a;
        avs_writedata_in  <= d;
        avs_byteenable_in <= be;
        avs_write_in      <= wr;
        avs_read_in       <= ~wr;
        do
        begin
            @(posedge clock_in);
        end
        while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_reset_state();
        @(negedge clock_in);
        chk(32'(analog_pin_out), 32'hFF);
        chk(32'(ref_sel_out), 32'(ACR_REF_RAILS));
        chk(32'(clock_div_out), 32'(ACR_DIV_2));
        chk(32'(use_rc_clock_out), 32'h0);
        bus_cycle(1'b0, ACR_CONFIG_ADDR, 32'h0, 4'hF, rd);
        chk(rd, 32'(ACR_CONFIG_RESET));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst_in = 1'b1;
        avs_address_in = 10'h000;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hF;
        conv_result_in = 10'h000;
        n_mismatch = 0;
        comparisons = 0;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        chk_reset_state();
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clock_in);
            conv_result_in <= 10'h2A5 + 10'(i * 37);
            bus_cycle(1'b1, ACR_CONTROL_ADDR, {24'h0, rows[i].ctl}, 4'hF, rd);
            bus_cycle(1'b1, ACR_CONFIG_ADDR, {24'h0, rows[i].cfg}, 4'hF, rd);
            @(negedge clock_in);
            chk(32'(analog_pin_out), 32'(rows[i].pins));
            chk(32'(ref_sel_out), 32'(rows[i].rf));
            @(negedge clock_in);
            chk(32'(clock_div_out), 32'(div_of(rows[i].cfg[6], rows[i].ctl[7:6])));
            chk(32'(use_rc_clock_out), 32'(rows[i].ctl[7:6] == 2'h3));
            chk({16'h0, result_high_byte_out, result_low_byte_out},
                32'(just_of(rows[i].cfg[7], conv_result_in)));
            bus_cycle(1'b0, ACR_CONFIG_ADDR, 32'h0, 4'hF, rd);
            chk(rd, 32'(rows[i].cfg & ACR_CONFIG_WMASK));
            bus_cycle(1'b0, ACR_CONTROL_ADDR, 32'h0, 4'hF, rd);
            chk(rd, 32'(rows[i].ctl));
            bus_cycle(1'b0, ACR_STATUS_ADDR, 32'h0, 4'hF, rd);
            chk(rd, 32'({rows[i].rf, rows[i].pins}));
            bus_cycle(1'b0, ACR_RESULT_ADDR, 32'h0, 4'hF, rd);
            chk(rd, 32'(just_of(rows[i].cfg[7], conv_result_in)));
        end
        // Lane 0 disabled and unmapped writes leave the register alone
        bus_cycle(1'b1, ACR_CONFIG_ADDR, 32'h80, 4'hE, rd);
        bus_cycle(1'b1, 10'h100, 32'hFF, 4'hF, rd);
        bus_cycle(1'b0, 10'h100, 32'h0, 4'hF, rd);
        chk(rd, 32'h0);
        bus_cycle(1'b0, ACR_CONFIG_ADDR, 32'h0, 4'hF, rd);
        chk(rd, 32'h4F);
        // Tick spacing at divide by sixteen
        bus_cycle(1'b1, ACR_CONTROL_ADDR, 32'h40, 4'hF, rd);
        repeat (3) @(posedge clock_in);
        n = 0;
        do
        begin
            @(negedge clock_in);
            n++;
        end
        while (conv_clock_tick_out !== 1'b1 && n < 200);
        n = 0;
        do
        begin
            @(negedge clock_in);
            n++;
        end
        while (conv_clock_tick_out !== 1'b1 && n < 200);
        chk(32'(n), 32'd16);
        // No ticks while the RC source is selected
        bus_cycle(1'b1, ACR_CONTROL_ADDR, 32'hC0, 4'hF, rd);
        repeat (2) @(posedge clock_in);
        n = 0;
        repeat (100)
        begin
            @(negedge clock_in);
            if (conv_clock_tick_out !== 1'b0)
                n++;
        end
        chk(32'(n), 32'd0);
        // Second reset in mid-run
        @(posedge clock_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        chk_reset_state();
        give_verdict();
    end
endmodule
`default_nettype wire
